// *** hdl/hls_pkg.sv ***
// hls_pkg: constants and carrier types for the host link select and lock block
package hls_pkg;

	// ----------------------------------------------------------------
	// host link select encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_SPI = 2'h0;
	localparam logic [1:0] SEL_I2C = 2'h1;
	localparam logic [1:0] SEL_LINE = 2'h2;

	// ----------------------------------------------------------------
	// lock key values
	// ----------------------------------------------------------------
	localparam logic [7:0] KEY_LOCK = 8'hAA;
	localparam logic [7:0] KEY_UNLOCK = 8'h00;

	// ----------------------------------------------------------------
	// memory map and frame layout
	// ----------------------------------------------------------------
	localparam logic [2:0] PAGE_TEST = 3'h0;
	localparam logic [7:0] CTRL_REG_ADDR_RST = 8'h00;
	localparam logic [6:0] I2C_ADDR_RST = 7'h20;
	localparam int HDR_RD_BIT = 7;
	localparam logic [1:0] IDX_HDR = 2'h0;
	localparam logic [1:0] IDX_ADR = 2'h1;
	localparam logic [1:0] IDX_DAT = 2'h2;
	localparam logic [1:0] IDX_END = 2'h3;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [3:0] I2C_ACK_SLOT = 4'h8;
	localparam logic [3:0] I2C_SLOT_END = 4'h9;
	localparam logic [4:0] SYNC_RST = 5'h1E;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic we;
		logic [2:0] page;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hls_mem_req_t;

	typedef struct packed {
		logic baud;
		logic sync;
		logic stop;
		logic cmd;
	} hls_fault_t;

	typedef enum logic [1:0] {I_IDLE, I_ADDR, I_RX, I_TX} hls_i2c_st_t;

endpackage

// *** hdl/hls_top.sv ***
// hls_top: host link select, spi and i2c slave, memory ownership and host lockout
`timescale 1ns/100ps

// Operation
// - transceiver enable low turns transceiver off and returns shared pin to dac driver.
// - link select other than one-wire re-enables dac driver; codes 0 and 1 select spi or i2c, code 3 selects neither.
// - either deactivation write may come first; each output follows its own bit.
// - four one-wire fault conditions are held in two sticky status registers.
// - spi side is slave only; transfers start only by the master.
// - every spi word shifts most significant bit first both ways.
// - chip select low addresses device; high holds spi logic in reset.
// - while chip select is high the serial output is not driven.
// - spi reaches non-test memory only when memory owner select is one.
// - spi input sampled on rising sck; output changes on rising sck.
// - i2c side is slave only; master starts transfers and supplies scl.
// - sda sampled while scl high, changed while low, except start and stop.
// - sda low reads zero, released reads one; device only pulls low.
// - i2c reaches non-test memory only when memory owner select is one.
// - cpu key 0xAA locks host link out of memory reads except test space.
// - while locked the cpu and link control test register is unreachable.
// - cpu key 0x00 while locked restores host link memory access.
// - the lock never restricts the embedded cpu.
// - a cpu watchdog reset leaves the lock in place.
// - one-wire select enables the one-wire controller and disconnects the dac.
// - i2c select switches the two general pins to data and clock roles.
module hls_top import hls_pkg::*; #(
	parameter logic [6:0] I2C_ADDR = I2C_ADDR_RST,
	parameter logic [7:0] CTRL_REG_ADDR = CTRL_REG_ADDR_RST
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// configuration bits
	input wire logic [1:0] host_link_select,
	input wire logic line_transceiver_on,
	input wire logic mem_owner_sel,
	input wire logic cpu_hold_reset,
	// cpu side lock key port and watchdog
	input wire logic lock_key_wr,
	input wire logic [7:0] lock_key_port,
	input wire logic cpu_wdt_reset,
	// one-wire fault events and clears
	input wire hls_fault_t line_fault_evt,
	input wire logic [1:0] line_fault_clr_a,
	input wire logic [1:0] line_fault_clr_b,
	output logic [1:0] line_fault_status_a,
	output logic [1:0] line_fault_status_b,
	// shared pin and mode steering
	output logic single_line_link_en,
	output logic line_transceiver_en,
	output logic shared_pin_to_line,
	output logic dac_driver_en,
	output logic general_pins_i2c_role,
	output logic cpu_reset_out,
	output logic host_locked,
	// spi pins
	input wire logic spi_sck,
	input wire logic spi_sdi,
	input wire logic spi_cs_n,
	output logic spi_sdo_o,
	output logic spi_sdo_oe_n,
	// i2c pins on the general pins
	input wire logic general_pin_three_i,
	input wire logic general_pin_one_i,
	output logic general_pin_one_o,
	output logic general_pin_one_oe_n,
	// memory port
	output logic mem_req,
	output hls_mem_req_t mem_cmd,
	input wire logic [7:0] mem_rdata
);

	// ----------------------------------------------------------------
	// pin synchronisers: {sda, scl, cs_n, sdi, sck}
	// ----------------------------------------------------------------
	logic [4:0] sy1_q, sy2_q, syp_q;
	logic [4:0] sy1_d, sy2_d, syp_d;
	logic sck_s, sdi_s, cs_s, scl_s, sda_s;
	logic sck_rise, scl_rise, scl_fall, i2c_start, i2c_stop;

	always_comb begin
		sy1_d = {general_pin_one_i, general_pin_three_i, spi_cs_n, spi_sdi, spi_sck};
		sy2_d = sy1_q;
		syp_d = sy2_q;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sy1_q <= SYNC_RST;
			sy2_q <= SYNC_RST;
			syp_q <= SYNC_RST;
		end else begin
			sy1_q <= sy1_d;
			sy2_q <= sy2_d;
			syp_q <= syp_d;
		end
	end

	assign sck_s = sy2_q[0];
	assign sdi_s = sy2_q[1];
	assign cs_s = sy2_q[2];
	assign scl_s = sy2_q[3];
	assign sda_s = sy2_q[4];
	assign sck_rise = sck_s & ~syp_q[0];
	assign scl_rise = scl_s & ~syp_q[3];
	assign scl_fall = ~scl_s & syp_q[3];
	assign i2c_start = scl_s & syp_q[3] & ~sda_s & syp_q[4];
	assign i2c_stop = scl_s & syp_q[3] & sda_s & ~syp_q[4];

	// ----------------------------------------------------------------
	// mode steering, faults and lock
	// ----------------------------------------------------------------
	logic [5:0] mode_q, mode_d;
	logic [1:0] fa_q, fa_d, fb_q, fb_d;
	logic lock_q, lock_d;
	logic spi_sel, i2c_sel;

	always_comb begin
		mode_d[0] = host_link_select == SEL_LINE;
		mode_d[1] = line_transceiver_on;
		mode_d[2] = line_transceiver_on;
		mode_d[3] = host_link_select != SEL_LINE;
		mode_d[4] = host_link_select == SEL_I2C;
		mode_d[5] = cpu_hold_reset;
		fa_d = (fa_q & ~line_fault_clr_a) | {line_fault_evt.baud, line_fault_evt.sync};
		fb_d = (fb_q & ~line_fault_clr_b) | {line_fault_evt.stop, line_fault_evt.cmd};
		lock_d = lock_q;
		if (lock_key_wr && lock_key_port == KEY_LOCK) begin
			lock_d = 1'b1;
		end else if (lock_key_wr && lock_key_port == KEY_UNLOCK && lock_q) begin
			lock_d = 1'b0;
		end
	end

	// the watchdog input reaches only the cpu, never the lock flop
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= 6'h08;
			fa_q <= 2'h0;
			fb_q <= 2'h0;
			lock_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			fa_q <= fa_d;
			fb_q <= fb_d;
			lock_q <= lock_d;
		end
	end

	assign single_line_link_en = mode_q[0];
	assign line_transceiver_en = mode_q[1];
	assign shared_pin_to_line = mode_q[2];
	assign dac_driver_en = mode_q[3];
	assign general_pins_i2c_role = mode_q[4];
	assign cpu_reset_out = mode_q[5] | cpu_wdt_reset;
	assign host_locked = lock_q;
	assign line_fault_status_a = fa_q;
	assign line_fault_status_b = fb_q;
	assign spi_sel = host_link_select == SEL_SPI;
	assign i2c_sel = host_link_select == SEL_I2C;

	// ----------------------------------------------------------------
	// access gate
	// ----------------------------------------------------------------
	function automatic logic allowed(input logic [2:0] page, input logic [7:0] addr, input logic we);
		logic ok;
		if (page == PAGE_TEST) begin
			ok = !(lock_q && addr == CTRL_REG_ADDR);
		end else begin
			ok = mem_owner_sel && !(lock_q && !we);
		end
		return ok;
	endfunction

	// ----------------------------------------------------------------
	// spi slave
	// ----------------------------------------------------------------
	logic [2:0] scnt_q, scnt_d;
	logic [7:0] srx_q, srx_d, stx_q, stx_d;
	logic spi_byte, spi_rd;
	logic [7:0] spi_b;
	logic pend_q, gnt_q;
	logic [7:0] rd_val;
	logic [1:0] idx_q;
	logic [7:0] hdr_q;

	assign rd_val = gnt_q ? mem_rdata : 8'h00;

	always_comb begin
		scnt_d = scnt_q;
		srx_d = srx_q;
		stx_d = stx_q;
		spi_byte = 1'b0;
		spi_b = {srx_q[6:0], sdi_s};
		if (cs_s || !spi_sel) begin
			scnt_d = 3'h0;
			srx_d = 8'h00;
			stx_d = 8'h00;
		end else begin
			if (sck_rise) begin
				srx_d = spi_b;
				stx_d = {stx_q[6:0], 1'b0};
				scnt_d = scnt_q + 3'h1;
				spi_byte = scnt_q == BIT_LAST;
			end
			if (pend_q) begin
				stx_d = rd_val;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			scnt_q <= 3'h0;
			srx_q <= 8'h00;
			stx_q <= 8'h00;
		end else begin
			scnt_q <= scnt_d;
			srx_q <= srx_d;
			stx_q <= stx_d;
		end
	end

	assign spi_rd = spi_byte && idx_q == IDX_ADR && hdr_q[HDR_RD_BIT];
	assign spi_sdo_o = stx_q[7];
	assign spi_sdo_oe_n = cs_s | ~spi_sel;

	// ----------------------------------------------------------------
	// i2c slave
	// ----------------------------------------------------------------
	hls_i2c_st_t ist_q, ist_d;
	logic [3:0] icnt_q, icnt_d;
	logic [7:0] ish_q, ish_d, itx_q, itx_d, rd_q;
	logic iack_q, iack_d;
	logic i2c_byte, i2c_rd;

	always_comb begin
		ist_d = ist_q;
		icnt_d = icnt_q;
		ish_d = ish_q;
		itx_d = itx_q;
		iack_d = iack_q;
		i2c_byte = 1'b0;
		i2c_rd = 1'b0;
		if (!i2c_sel) begin
			ist_d = I_IDLE;
			icnt_d = 4'h0;
			iack_d = 1'b0;
		end else if (i2c_start) begin
			ist_d = I_ADDR;
			icnt_d = 4'h0;
			iack_d = 1'b0;
		end else if (i2c_stop) begin
			ist_d = I_IDLE;
			iack_d = 1'b0;
		end else if (ist_q != I_IDLE && scl_rise) begin
			if (icnt_q < I2C_ACK_SLOT) begin
				ish_d = {ish_q[6:0], sda_s};
			end else if (ist_q == I_TX && sda_s) begin
				ist_d = I_IDLE;
			end
			icnt_d = icnt_q + 4'h1;
		end else if (ist_q != I_IDLE && scl_fall) begin
			if (icnt_q == I2C_ACK_SLOT) begin
				case (ist_q)
					I_ADDR: begin
						if (ish_q[7:1] == I2C_ADDR) begin
							iack_d = 1'b1;
							ist_d = ish_q[0] ? I_TX : I_RX;
							i2c_rd = ish_q[0];
						end else begin
							ist_d = I_IDLE;
						end
					end
					I_RX: begin
						iack_d = 1'b1;
						i2c_byte = 1'b1;
					end
					default: begin
						iack_d = 1'b0;
						// let go only after scl has fallen, so the master may ack
						itx_d = 8'hFF;
					end
				endcase
			end else if (icnt_q == I2C_SLOT_END) begin
				icnt_d = 4'h0;
				iack_d = 1'b0;
				itx_d = rd_q;
			end else if (ist_q == I_TX) begin
				itx_d = {itx_q[6:0], 1'b1};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ist_q <= I_IDLE;
			icnt_q <= 4'h0;
			ish_q <= 8'h00;
			itx_q <= 8'h00;
			iack_q <= 1'b0;
		end else begin
			ist_q <= ist_d;
			icnt_q <= icnt_d;
			ish_q <= ish_d;
			itx_q <= itx_d;
			iack_q <= iack_d;
		end
	end

	assign general_pin_one_o = 1'b0;
	assign general_pin_one_oe_n = ~(i2c_sel & (iack_q | (ist_q == I_TX & ~itx_q[7])));

	// ----------------------------------------------------------------
	// shared frame engine and memory port
	// ----------------------------------------------------------------
	logic [1:0] idx_d;
	logic [7:0] hdr_d, adr_q, adr_d, rd_d;
	logic pend_d, gnt_d, req_q, req_d, any_byte;
	logic [7:0] any_b;
	hls_mem_req_t cmd_q, cmd_d;

	assign any_byte = spi_byte | i2c_byte;
	assign any_b = spi_byte ? spi_b : ish_q;

	always_comb begin
		idx_d = idx_q;
		hdr_d = hdr_q;
		adr_d = adr_q;
		cmd_d = cmd_q;
		req_d = 1'b0;
		pend_d = 1'b0;
		gnt_d = gnt_q;
		rd_d = pend_q ? rd_val : rd_q;
		if ((cs_s && spi_sel) || i2c_start) begin
			idx_d = IDX_HDR;
		end else if (any_byte && idx_q != IDX_END) begin
			idx_d = idx_q + 2'h1;
			if (idx_q == IDX_HDR) begin
				hdr_d = any_b;
			end else if (idx_q == IDX_ADR) begin
				adr_d = any_b;
			end
		end
		if (spi_rd || i2c_rd) begin
			cmd_d = '{we: 1'b0, page: hdr_q[2:0], addr: spi_rd ? spi_b : adr_q, wdata: 8'h00};
			gnt_d = allowed(cmd_d.page, cmd_d.addr, 1'b0);
			req_d = gnt_d;
			pend_d = 1'b1;
		end else if (any_byte && idx_q == IDX_DAT && !hdr_q[HDR_RD_BIT]) begin
			cmd_d = '{we: 1'b1, page: hdr_q[2:0], addr: adr_q, wdata: any_b};
			req_d = allowed(cmd_d.page, cmd_d.addr, 1'b1);
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			idx_q <= IDX_HDR;
			hdr_q <= 8'h00;
			adr_q <= 8'h00;
			cmd_q <= '0;
			req_q <= 1'b0;
			pend_q <= 1'b0;
			gnt_q <= 1'b0;
			rd_q <= 8'h00;
		end else begin
			idx_q <= idx_d;
			hdr_q <= hdr_d;
			adr_q <= adr_d;
			cmd_q <= cmd_d;
			req_q <= req_d;
			pend_q <= pend_d;
			gnt_q <= gnt_d;
			rd_q <= rd_d;
		end
	end

	assign mem_req = req_q;
	assign mem_cmd = cmd_q;

endmodule

// *** dv/hls_top_properties.sv ***
// hls_top_properties: port level checks for hls_top
`timescale 1ns/100ps
module hls_top_properties import hls_pkg::*; #(
	parameter logic [7:0] CTRL_REG_ADDR = CTRL_REG_ADDR_RST
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// watched inputs
	input wire logic [1:0] host_link_select,
	input wire logic line_transceiver_on,
	input wire logic mem_owner_sel,
	input wire logic lock_key_wr,
	input wire logic [7:0] lock_key_port,
	input wire hls_fault_t line_fault_evt,
	input wire logic spi_cs_n,
	input wire logic general_pin_three_i,
	// watched outputs
	input wire logic single_line_link_en,
	input wire logic line_transceiver_en,
	input wire logic shared_pin_to_line,
	input wire logic dac_driver_en,
	input wire logic general_pins_i2c_role,
	input wire logic host_locked,
	input wire logic [1:0] line_fault_status_a,
	input wire logic [1:0] line_fault_status_b,
	input wire logic spi_sdo_oe_n,
	input wire logic general_pin_one_o,
	input wire logic general_pin_one_oe_n,
	input wire logic mem_req,
	input wire hls_mem_req_t mem_cmd
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_dac_sel: assert property ($past(resetn) |->
		dac_driver_en == ($past(host_link_select) != SEL_LINE)) else $error("dac enable wrong");
	a_line_ctrl_on: assert property ($past(resetn) |->
		single_line_link_en == ($past(host_link_select) == SEL_LINE)) else $error("line link enable wrong");
	a_xcvr_follow: assert property ($past(resetn) |->
		line_transceiver_en == $past(line_transceiver_on) && shared_pin_to_line == line_transceiver_en)
		else $error("transceiver steering wrong");
	a_i2c_pin_role: assert property ($past(resetn) |->
		general_pins_i2c_role == ($past(host_link_select) == SEL_I2C)) else $error("pin role wrong");
	a_lock_set: assert property (lock_key_wr && lock_key_port == KEY_LOCK |=> host_locked)
		else $error("lock key not taken");
	a_lock_clear: assert property (lock_key_wr && lock_key_port == KEY_UNLOCK |=> !host_locked)
		else $error("unlock key not taken");
	a_lock_hold: assert property (!lock_key_wr |=> $stable(host_locked))
		else $error("lock changed without key");
	a_lock_read_gate: assert property (mem_req && host_locked |-> mem_cmd.we || mem_cmd.page == PAGE_TEST)
		else $error("locked read reached memory");
	a_lock_ctrl_reg: assert property (mem_req && host_locked |->
		!(mem_cmd.page == PAGE_TEST && mem_cmd.addr == CTRL_REG_ADDR)) else $error("locked control access");
	a_owner_gate: assert property (mem_req && mem_cmd.page != PAGE_TEST |-> mem_owner_sel)
		else $error("memory reached without ownership");
	a_sdo_tristate: assert property (spi_cs_n [*4] |-> spi_sdo_oe_n)
		else $error("sdo driven while deselected");
	a_sda_pull_low: assert property (!general_pin_one_oe_n |-> !general_pin_one_o)
		else $error("sda driven high");
	a_sda_hold_scl: assert property (general_pin_three_i [*4] |-> $stable(general_pin_one_oe_n))
		else $error("sda changed while scl high");
	a_fault_sticky: assert property (|line_fault_evt |=>
		({line_fault_status_a, line_fault_status_b} & $past(line_fault_evt)) == $past(line_fault_evt))
		else $error("fault flag not set");
endmodule

bind hls_top hls_top_properties #(.CTRL_REG_ADDR(CTRL_REG_ADDR)) u_hls_top_properties (
	.ref_clk(ref_clk), .resetn(resetn), .host_link_select(host_link_select),
	.line_transceiver_on(line_transceiver_on), .mem_owner_sel(mem_owner_sel), .lock_key_wr(lock_key_wr),
	.lock_key_port(lock_key_port), .line_fault_evt(line_fault_evt), .spi_cs_n(spi_cs_n),
	.general_pin_three_i(general_pin_three_i),
	.single_line_link_en(single_line_link_en), .line_transceiver_en(line_transceiver_en),
	.shared_pin_to_line(shared_pin_to_line), .dac_driver_en(dac_driver_en),
	.general_pins_i2c_role(general_pins_i2c_role), .host_locked(host_locked),
	.line_fault_status_a(line_fault_status_a), .line_fault_status_b(line_fault_status_b),
	.spi_sdo_oe_n(spi_sdo_oe_n), .general_pin_one_o(general_pin_one_o),
	.general_pin_one_oe_n(general_pin_one_oe_n), .mem_req(mem_req), .mem_cmd(mem_cmd)
);

// *** dv/hls_spi_master.sv ***
// hls_spi_master: external spi master (sck idle low) and i2c master, both 160 ns per bit
`timescale 1ns/100ps
module hls_spi_master (
	// clock
	input wire logic ref_clk,
	// device side
	input wire logic sdo_i,
	input wire logic sdo_oe_n,
	// master pins
	output logic sck,
	output logic sdi,
	output logic cs_n
);
	initial begin
		sck = 1'b0;
		sdi = 1'b0;
		cs_n = 1'b1;
	end

	task automatic half;
		repeat (16) @(posedge ref_clk);
		#1;
	endtask

	// only this model starts frames; sdo read just before each rise
	task automatic frame(input logic [23:0] tx, output logic [7:0] rx);
		int i;
		cs_n = 1'b0;
		for (i = 23; i >= 0; i--) begin
			sdi = tx[i];
			half();
			rx = {rx[6:0], sdo_oe_n ? 1'bx : sdo_i};
			sck = 1'b1;
			half();
			sck = 1'b0;
		end
		half();
		cs_n = 1'b1;
		sdi = ~sdi;
	endtask
endmodule

module hls_i2c_master (
	// clock
	input wire logic ref_clk,
	// line as seen on the wire
	input wire logic sda_i,
	// master drivers, sda_drv low pulls the line low
	output logic scl,
	output logic sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic qtr;
		repeat (8) @(posedge ref_clk);
		#1;
	endtask

	// data moves only while scl is low; sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		qtr();
		scl = 1'b1;
		qtr();
		r = sda_i;
		qtr();
		scl = 1'b0;
		qtr();
	endtask

	// start from idle, or repeated start with scl low
	task automatic cond_start;
		sda_drv = 1'b1;
		qtr();
		scl = 1'b1;
		qtr();
		sda_drv = 1'b0;
		qtr();
		scl = 1'b0;
		qtr();
	endtask

	task automatic cond_stop;
		sda_drv = 1'b0;
		qtr();
		scl = 1'b1;
		qtr();
		sda_drv = 1'b1;
		qtr();
	endtask

	// one byte out msb first, slave ack bit returned
	task automatic put(input logic [7:0] b, output logic ack);
		int i;
		logic r;
		for (i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, ack);
	endtask

	// one byte in, then ack (0) or nack (1)
	task automatic get(input logic nack, output logic [7:0] b);
		int i;
		logic r;
		for (i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(nack, r);
	endtask
endmodule

// *** dv/test_hls_top.sv ***
// test_hls_top: directed bench for hls_top
`timescale 1ns/100ps
`define chk(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
	$display("Error t=%0t got %0h exp %0h", $time, a, b); end end
module test_hls_top import hls_pkg::*;;
	logic ref_clk = 1'b0;
	logic resetn, xcvr_on, owner, hold, key_wr, wdt, sck, sdi, cs_n, sdo, sdo_oe_n, sda_o, sda_oe_n, scl, m_sda;
	logic line_en, xcvr_en, pin_line, dac_en, i2c_role, cpu_rst, locked, mem_req;
	logic [1:0] sel, clr_a, clr_b, st_a, st_b;
	logic [7:0] key, rx;
	logic [7:0] mem_rdata = 8'h00;
	hls_fault_t evt;
	hls_mem_req_t mem_cmd, last_cmd;
	int n_fail, check_count, n_req, i, j;
	// wired and with pull-up: either side may only pull low
	wire sda = (sda_oe_n | sda_o) & m_sda;

	always #2.5 ref_clk = ~ref_clk;

	hls_top u_hls_top (.ref_clk(ref_clk), .resetn(resetn), .host_link_select(sel),
		.line_transceiver_on(xcvr_on), .mem_owner_sel(owner), .cpu_hold_reset(hold), .lock_key_wr(key_wr),
		.lock_key_port(key), .cpu_wdt_reset(wdt), .line_fault_evt(evt), .line_fault_clr_a(clr_a),
		.line_fault_clr_b(clr_b), .line_fault_status_a(st_a), .line_fault_status_b(st_b),
		.single_line_link_en(line_en), .line_transceiver_en(xcvr_en), .shared_pin_to_line(pin_line),
		.dac_driver_en(dac_en), .general_pins_i2c_role(i2c_role), .cpu_reset_out(cpu_rst),
		.host_locked(locked), .spi_sck(sck), .spi_sdi(sdi), .spi_cs_n(cs_n), .spi_sdo_o(sdo),
		.spi_sdo_oe_n(sdo_oe_n), .general_pin_three_i(scl), .general_pin_one_i(sda),
		.general_pin_one_o(sda_o), .general_pin_one_oe_n(sda_oe_n), .mem_req(mem_req),
		.mem_cmd(mem_cmd), .mem_rdata(mem_rdata));

	hls_spi_master u_hls_spi_master (.ref_clk(ref_clk), .sdo_i(sdo), .sdo_oe_n(sdo_oe_n),
		.sck(sck), .sdi(sdi), .cs_n(cs_n));

	hls_i2c_master u_hls_i2c_master (.ref_clk(ref_clk), .sda_i(sda), .scl(scl), .sda_drv(m_sda));

	// ------------------------------------------------------------
	// memory responder: read data is a function of the address
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		#1;
		if (mem_req) begin
			n_req++;
			last_cmd = mem_cmd;
			mem_rdata = mem_cmd.addr ^ 8'h5A;
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic key_put(input logic [7:0] k);
		key = k;
		key_wr = 1'b1;
		tick(1);
		key_wr = 1'b0;
		tick(1);
	endtask

	task automatic spi(input logic rd, input logic [2:0] pg, input logic [7:0] ad, input logic [7:0] dt,
		input int req, input logic [7:0] exp);
		int n0;
		n0 = n_req;
		u_hls_spi_master.frame({rd, 4'h0, pg, ad, dt}, rx);
		tick(20);
		`chk(n_req - n0, req)
		if (rd) `chk(rx, exp)
		if (req == 1 && !rd) `chk(last_cmd, {1'b1, pg, ad, dt})
		if (req == 1 && rd) `chk(last_cmd, {1'b0, pg, ad, 8'h00})
	endtask

	task automatic i2c_wr(input logic [6:0] dev, input logic [2:0] pg, input logic [7:0] ad, input logic [7:0] dt,
		input int req);
		int n0;
		logic a;
		n0 = n_req;
		u_hls_i2c_master.cond_start();
		u_hls_i2c_master.put({dev, 1'b0}, a);
		`chk(a, (dev != I2C_ADDR_RST))
		if (!a) begin
			u_hls_i2c_master.put({5'h00, pg}, a);
			u_hls_i2c_master.put(ad, a);
			u_hls_i2c_master.put(dt, a);
			`chk(a, 1'b0)
		end
		u_hls_i2c_master.cond_stop();
		tick(20);
		`chk(n_req - n0, req)
		if (req == 1) `chk(last_cmd, {1'b1, pg, ad, dt})
	endtask

	task automatic i2c_rd(input logic [2:0] pg, input logic [7:0] ad, input logic [7:0] exp);
		int n0;
		logic a;
		logic [7:0] b;
		n0 = n_req;
		u_hls_i2c_master.cond_start();
		u_hls_i2c_master.put({I2C_ADDR_RST, 1'b0}, a);
		u_hls_i2c_master.put({5'h00, pg}, a);
		u_hls_i2c_master.put(ad, a);
		u_hls_i2c_master.cond_start();
		u_hls_i2c_master.put({I2C_ADDR_RST, 1'b1}, a);
		`chk(a, 1'b0)
		u_hls_i2c_master.get(1'b0, b);
		`chk(b, exp)
		u_hls_i2c_master.get(1'b1, b);
		`chk(b, exp)
		u_hls_i2c_master.cond_stop();
		tick(20);
		`chk(n_req - n0, 1)
		`chk(last_cmd, {1'b0, pg, ad, 8'h00})
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		#200000;
		n_fail++;
		stop_test();
	end

	initial begin
		{sel, xcvr_on, owner, hold, key_wr, key, wdt, evt, clr_a, clr_b} = '0;
		resetn = 1'b0;
		tick(6);
		resetn = 1'b1;
		`chk({dac_en, locked, sdo_oe_n}, 3'h5)
		for (i = 0; i < 4; i++) begin
			sel = i[1:0];
			tick(2);
			`chk(line_en, (i == 2))
			`chk(dac_en, (i != 2))
			`chk(i2c_role, (i == 1))
		end
		// leave single line mode in both orders
		for (j = 0; j < 2; j++) begin
			sel = SEL_LINE;
			xcvr_on = 1'b1;
			tick(2);
			`chk({dac_en, pin_line, xcvr_en}, 3'h3)
			if (j == 1) sel = SEL_SPI;
			else xcvr_on = 1'b0;
			tick(2);
			`chk({dac_en, pin_line, xcvr_en}, {3{(j == 1)}})
			sel = SEL_SPI;
			xcvr_on = 1'b0;
			tick(2);
			`chk({dac_en, pin_line, line_en, xcvr_en}, 4'h8)
		end
		for (i = 0; i < 4; i++) begin
			evt = 4'h8 >> i;
			tick(1);
			evt = '0;
			tick(2);
			`chk({st_a, st_b}, 4'h8 >> i)
			{clr_a, clr_b} = 4'hF;
			tick(1);
			{clr_a, clr_b} = '0;
			tick(1);
			`chk({st_a, st_b}, 4'h0)
		end
		hold = 1'b1;
		tick(2);
		`chk(cpu_rst, 1'b1)
		spi(1'b0, PAGE_TEST, 8'h10, 8'hC3, 1, 8'h00);
		spi(1'b0, 3'h1, 8'h20, 8'h11, 0, 8'h00);
		owner = 1'b1;
		tick(2);
		spi(1'b0, 3'h1, 8'h20, 8'h11, 1, 8'h00);
		spi(1'b1, 3'h2, 8'h33, 8'h00, 1, 8'h69);
		key_put(KEY_LOCK);
		`chk(locked, 1'b1)
		spi(1'b1, 3'h2, 8'h33, 8'h00, 0, 8'h00);
		spi(1'b1, PAGE_TEST, CTRL_REG_ADDR_RST, 8'h00, 0, 8'h00);
		spi(1'b1, PAGE_TEST, 8'h10, 8'h00, 1, 8'h4A);
		wdt = 1'b1;
		tick(2);
		wdt = 1'b0;
		key_put(8'h55);
		`chk(locked, 1'b1)
		key_put(KEY_UNLOCK);
		`chk(locked, 1'b0)
		spi(1'b1, 3'h2, 8'h33, 8'h00, 1, 8'h69);
		// i2c: hold and ownership are already high, select comes last
		sel = SEL_I2C;
		tick(2);
		`chk({i2c_role, sda_oe_n}, 2'h3)
		i2c_wr(I2C_ADDR_RST, 3'h1, 8'h44, 8'h96, 1);
		i2c_rd(3'h2, 8'h33, 8'h69);
		i2c_wr(7'h21, 3'h1, 8'h44, 8'h96, 0);
		owner = 1'b0;
		tick(2);
		i2c_wr(I2C_ADDR_RST, 3'h1, 8'h44, 8'h96, 0);
		i2c_wr(I2C_ADDR_RST, PAGE_TEST, 8'h10, 8'h3C, 1);
		stop_test();
	end
endmodule
